//--- logic/cpu_seq_pkg.sv
// Behaviour
// - Instruction address counter is a nine-bit binary counter selecting one program word.
// - Each ordinary instruction advances the instruction address counter by one.
// - Jump, subroutine invoke and subroutine exit load their target address.
// - Skip always advances; when its condition holds the next instruction acts as no-op.
// - One-entry return stack captures the return address on every subroutine invoke.
// - Reset clears the instruction address counter so execution starts at address zero.
// - Program memory holds 512 sixteen-bit words, one instruction per address.
// - Data memory is nibble addressed: upper three bits row, lower four bits column.
// - Row pointer is fixed at zero, so general register operands live in row zero.
// - Writing a port register turns the port to output and drives it until reset.
// - Reading a port register returns the pin levels, in input and output mode.
// - Addresses 74H through 7DH always read zero and ignore writes.
// - Decimal flag is bit 0 of 7EH; 7FH holds compare bit 3, carry 2, null 1.
// - Upper three bits of 7EH and bit 0 of 7FH always read zero.
// - Non-zero result clears the null flag; zero sets it only while compare hold clear.
// - With compare hold set a zero result leaves the null flag unchanged.
// - Arithmetic sets carry on carry out or borrow and clears it otherwise.
// - Rotate right through carry loads carry with the operand least significant bit.
// - With compare hold set arithmetic results are not written back; flags still update.
// - Either bit-test skip instruction clears the compare hold flag.
// - Decimal flag set gives one-digit decimal arithmetic; clear gives four-bit binary.
// - Compare skips leave carry alone; arithmetic updates carry even under compare hold.
// - Reset sets every status word bit to zero.
// - The datapath status flags and the status word are the same storage.
package cpu_seq_pkg;

    // Sizes
    localparam int PC_W       = 9;
    localparam int ROM_DEPTH  = 512;
    localparam int ROM_W      = 16;
    localparam int NIB_W      = 4;
    localparam int DADDR_W    = 7;
    localparam int DMEM_DEPTH = 128;
    localparam int PORT_NUM   = 3;
    localparam int PIN_W      = PORT_NUM * NIB_W;

    // Data memory map
    localparam logic [DADDR_W-1:0] PORT_BASE_ADDR   = 7'h70;
    localparam logic [DADDR_W-1:0] PORT_LAST_ADDR   = 7'h72;
    localparam logic [DADDR_W-1:0] ZERO_FIRST_ADDR  = 7'h74;
    localparam logic [DADDR_W-1:0] ZERO_LAST_ADDR   = 7'h7d;
    localparam logic [DADDR_W-1:0] STATUS_LOW_ADDR  = 7'h7e;
    localparam logic [DADDR_W-1:0] STATUS_FLAG_ADDR = 7'h7f;
    localparam logic [2:0]         GEN_ROW          = 3'h0;

    // Status word bit positions
    localparam int BCD_BIT = 0;
    localparam int CMP_BIT = 3;
    localparam int CY_BIT  = 2;
    localparam int Z_BIT   = 1;

    // Reset values and arithmetic constants
    localparam logic [PC_W-1:0]  RESET_PC    = 9'h000;
    localparam logic [PC_W-1:0]  PC_STEP     = 9'h001;
    localparam logic [NIB_W-1:0] STATUS_RST  = 4'h0;
    localparam logic [NIB_W-1:0] NIB_ZERO    = 4'h0;
    localparam logic [NIB_W-1:0] NIB_ONES    = 4'hf;
    localparam logic [4:0]       BCD_LIMIT   = 5'h09;
    localparam logic [4:0]       BCD_ADJ5    = 5'h06;
    localparam logic [NIB_W-1:0] BCD_ADJ4    = 4'h6;

    // Instruction fields
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 11;
    localparam int MA_HI  = 10;
    localparam int MA_LO  = 4;
    localparam int TGT_HI = 8;

    // Opcodes; for 0..13 bit 0 selects the memory-immediate form
    localparam logic [4:0] OP_ADD_RM  = 5'h00;
    localparam logic [4:0] OP_SUBC_MI = 5'h07;
    localparam logic [4:0] OP_OR_RM   = 5'h08;
    localparam logic [4:0] OP_XOR_MI  = 5'h0d;
    localparam logic [4:0] OP_SKT     = 5'h0e;
    localparam logic [4:0] OP_SKF     = 5'h0f;
    localparam logic [4:0] OP_SKE     = 5'h10;
    localparam logic [4:0] OP_SKIP_IF_UNEQUAL    = 5'h11;
    localparam logic [4:0] OP_SKIP_IF_NOT_LESS    = 5'h12;
    localparam logic [4:0] OP_SKIP_IF_BELOW    = 5'h13;
    localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY    = 5'h14;
    localparam logic [4:0] OP_LD      = 5'h15;
    localparam logic [4:0] OP_ST      = 5'h16;
    localparam logic [4:0] OP_MOVI    = 5'h17;
    localparam logic [4:0] OP_JUMP    = 5'h18;
    localparam logic [4:0] OP_CALL    = 5'h19;
    localparam logic [4:0] OP_RET     = 5'h1a;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic bcd;
        logic cmp;
        logic cy;
        logic z;
    } flags_s;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] lvl;
    } pin_sync_s;

    typedef struct packed {
        seq_state_e        fsm;
        logic [ROM_W-1:0]  instr;
        logic [PC_W-1:0]   pc;
        logic [PC_W-1:0]   ret_stack;
        logic              skip;
        flags_s            flags;
        logic [PIN_W-1:0]  port_data;
        logic [PIN_W-1:0]  port_oe;
        pin_sync_s         sync;
    } core_state_s;

endpackage : cpu_seq_pkg

//--- logic/cpu_sequencer_and_status_word.sv
`timescale 1ns/10ps
module cpu_sequencer_and_status_word (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              arst_n_i,
    // Program memory load and run control
    input  wire logic                              prog_we_i,
    input  wire logic [cpu_seq_pkg::PC_W-1:0]      prog_addr_i,
    input  wire logic [cpu_seq_pkg::ROM_W-1:0]     prog_wdata_i,
    input  wire logic                              hold_i,
    // Port pins
    input  wire logic [cpu_seq_pkg::PIN_W-1:0]     pin_i,
    output logic      [cpu_seq_pkg::PIN_W-1:0]     pin_o,
    output logic      [cpu_seq_pkg::PIN_W-1:0]     pin_oe_o,
    // Observation
    output logic      [cpu_seq_pkg::PC_W-1:0]      instr_addr_o,
    output logic      [cpu_seq_pkg::NIB_W-1:0]     status_flag_nibble_o,
    output logic      [cpu_seq_pkg::NIB_W-1:0]     status_word_o
);

    // Memories
    logic [cpu_seq_pkg::ROM_W-1:0]  rom [cpu_seq_pkg::ROM_DEPTH];
    logic [cpu_seq_pkg::NIB_W-1:0]  dmem [cpu_seq_pkg::DMEM_DEPTH];

    // State and next state
    cpu_seq_pkg::core_state_s       st_r;
    cpu_seq_pkg::core_state_s       st_nxt;

    // Decode and operand wires
    logic [4:0]                         opc;
    logic [cpu_seq_pkg::DADDR_W-1:0]    m_addr;
    logic [cpu_seq_pkg::DADDR_W-1:0]    r_addr;
    logic [cpu_seq_pkg::NIB_W-1:0]      imm;
    logic [cpu_seq_pkg::PC_W-1:0]       tgt;
    logic [cpu_seq_pkg::PC_W-1:0]       pc_inc;
    logic [cpu_seq_pkg::ROM_W-1:0]      rom_word;
    logic [cpu_seq_pkg::NIB_W-1:0]      m_val;
    logic [cpu_seq_pkg::NIB_W-1:0]      r_val;

    // Data memory write port
    logic                               dm_we;
    logic [cpu_seq_pkg::DADDR_W-1:0]    dm_waddr;
    logic [cpu_seq_pkg::NIB_W-1:0]      dm_wdata;

    // Address falls on a port register
    function automatic logic is_port(input logic [cpu_seq_pkg::DADDR_W-1:0] a);
        is_port = (a >= cpu_seq_pkg::PORT_BASE_ADDR) && (a <= cpu_seq_pkg::PORT_LAST_ADDR);
    endfunction : is_port

    // Address falls in the always-zero system area
    function automatic logic is_zero_area(input logic [cpu_seq_pkg::DADDR_W-1:0] a);
        is_zero_area = (a >= cpu_seq_pkg::ZERO_FIRST_ADDR) && (a <= cpu_seq_pkg::ZERO_LAST_ADDR);
    endfunction : is_zero_area

    // Nibble read with the whole data memory map applied
    function automatic logic [cpu_seq_pkg::NIB_W-1:0] read_nib(
        input logic [cpu_seq_pkg::DADDR_W-1:0] a,
        input logic [cpu_seq_pkg::NIB_W-1:0]   raw,
        input logic [cpu_seq_pkg::PIN_W-1:0]   pins,
        input cpu_seq_pkg::flags_s             fl
    );
        logic [cpu_seq_pkg::NIB_W-1:0] v;
        v = cpu_seq_pkg::NIB_ZERO;
        if (is_port(a))
        begin
            v = pins[{a[1:0], 2'b00} +: cpu_seq_pkg::NIB_W];
        end
        else if (is_zero_area(a))
        begin
            v = cpu_seq_pkg::NIB_ZERO;
        end
        else if (a == cpu_seq_pkg::STATUS_LOW_ADDR)
        begin
            v[cpu_seq_pkg::BCD_BIT] = fl.bcd;
        end
        else if (a == cpu_seq_pkg::STATUS_FLAG_ADDR)
        begin
            v[cpu_seq_pkg::CMP_BIT] = fl.cmp;
            v[cpu_seq_pkg::CY_BIT]  = fl.cy;
            v[cpu_seq_pkg::Z_BIT]   = fl.z;
        end
        else
        begin
            v = raw;
        end
        read_nib = v;
    endfunction : read_nib

    // Add or subtract one nibble, binary or one decimal digit; returns {carry, result}
    function automatic logic [4:0] arith(
        input logic [cpu_seq_pkg::NIB_W-1:0] a,
        input logic [cpu_seq_pkg::NIB_W-1:0] b,
        input logic                          cin,
        input logic                          sub,
        input logic                          bcd
    );
        logic [4:0] s;
        logic [4:0] t;
        s = 5'h00;
        t = 5'h00;
        if (!sub)
        begin
            s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
            if (bcd && (s > cpu_seq_pkg::BCD_LIMIT))
            begin
                t = s + cpu_seq_pkg::BCD_ADJ5;
                s = {1'b1, t[3:0]};
            end
        end
        else
        begin
            s = {1'b0, a} - {1'b0, b} - {4'h0, cin};
            if (bcd && s[4])
            begin
                s = {1'b1, s[3:0] - cpu_seq_pkg::BCD_ADJ4};
            end
        end
        arith = s;
    endfunction : arith

    // Instruction fields
    assign opc      = st_r.instr[cpu_seq_pkg::OPC_HI:cpu_seq_pkg::OPC_LO];
    assign m_addr   = st_r.instr[cpu_seq_pkg::MA_HI:cpu_seq_pkg::MA_LO];
    assign imm      = st_r.instr[cpu_seq_pkg::NIB_W-1:0];
    assign tgt      = st_r.instr[cpu_seq_pkg::TGT_HI:0];
    assign r_addr   = {cpu_seq_pkg::GEN_ROW, imm};
    assign pc_inc   = st_r.pc + cpu_seq_pkg::PC_STEP;
    assign rom_word = rom[st_r.pc];
    // row and column form the nibble address
    assign m_val    = read_nib(m_addr, dmem[m_addr], st_r.sync.lvl, st_r.flags);
    assign r_val    = read_nib(r_addr, dmem[r_addr], st_r.sync.lvl, st_r.flags);

    // Next-state logic: pin synchroniser, fetch, execute, write-back
    always_comb
    begin
        logic                            do_wr;
        logic [cpu_seq_pkg::DADDR_W-1:0] wr_a;
        logic [cpu_seq_pkg::NIB_W-1:0]   wr_d;
        logic                            fl_upd;
        logic [4:0]                      res;
        logic [cpu_seq_pkg::NIB_W-1:0]   lres;
        logic [cpu_seq_pkg::NIB_W-1:0]   opa;
        logic [cpu_seq_pkg::NIB_W-1:0]   opb;
        logic [cpu_seq_pkg::DADDR_W-1:0] dst;
        do_wr    = 1'b0;
        wr_a     = '0;
        wr_d     = '0;
        fl_upd   = 1'b0;
        res      = 5'h00;
        lres     = '0;
        opa      = '0;
        opb      = '0;
        dst      = '0;
        st_nxt   = st_r;
        dm_we    = 1'b0;
        dm_waddr = '0;
        dm_wdata = '0;

        // Pin levels: take a change once the second and third stages agree
        st_nxt.sync.s1 = pin_i;
        st_nxt.sync.s2 = st_r.sync.s1;
        st_nxt.sync.s3 = st_r.sync.s2;
        if (st_r.sync.s2 == st_r.sync.s3)
        begin
            st_nxt.sync.lvl = st_r.sync.s3;
        end

        // Operand selection shared by arithmetic and logic groups
        opa = st_r.instr[cpu_seq_pkg::OPC_LO] ? m_val : r_val;
        opb = st_r.instr[cpu_seq_pkg::OPC_LO] ? imm : m_val;
        dst = st_r.instr[cpu_seq_pkg::OPC_LO] ? m_addr : r_addr;

        case (st_r.fsm)
            cpu_seq_pkg::ST_FETCH:
            begin
                if (!hold_i)
                begin
                    st_nxt.instr = rom_word;
                    st_nxt.fsm   = cpu_seq_pkg::ST_EXEC;
                end
            end
            cpu_seq_pkg::ST_EXEC:
            begin
                st_nxt.fsm = cpu_seq_pkg::ST_FETCH;
                st_nxt.pc  = pc_inc;
                if (st_r.skip)
                begin
                    st_nxt.skip = 1'b0;
                end
                else if (opc <= cpu_seq_pkg::OP_SUBC_MI)
                begin
                    // carry from carry out or borrow
                    res = arith(opa, opb, opc[1] & st_r.flags.cy, opc[2], st_r.flags.bcd);
                    fl_upd = 1'b1;
                    do_wr = !st_r.flags.cmp;
                    wr_a  = dst;
                    wr_d  = res[3:0];
                end
                else if (opc <= cpu_seq_pkg::OP_XOR_MI)
                begin
                    case (opc[2:1])
                        2'b00:   lres = opa | opb;
                        2'b01:   lres = opa & opb;
                        default: lres = opa ^ opb;
                    endcase
                    do_wr = 1'b1;
                    wr_a  = dst;
                    wr_d  = lres;
                end
                else
                begin
                    case (opc)
                        cpu_seq_pkg::OP_SKT:
                        begin
                            st_nxt.flags.cmp = 1'b0;
                            st_nxt.skip      = (m_val & imm) == imm;
                        end
                        cpu_seq_pkg::OP_SKF:
                        begin
                            st_nxt.flags.cmp = 1'b0;
                            st_nxt.skip      = (m_val & imm) == cpu_seq_pkg::NIB_ZERO;
                        end
                        cpu_seq_pkg::OP_SKE:  st_nxt.skip = m_val == imm;
                        cpu_seq_pkg::OP_SKIP_IF_UNEQUAL: st_nxt.skip = m_val != imm;
                        cpu_seq_pkg::OP_SKIP_IF_NOT_LESS: st_nxt.skip = m_val >= imm;
                        cpu_seq_pkg::OP_SKIP_IF_BELOW: st_nxt.skip = m_val < imm;
                        cpu_seq_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY:
                        begin
                            st_nxt.flags.cy = r_val[0];
                            do_wr = 1'b1;
                            wr_a  = r_addr;
                            wr_d  = {st_r.flags.cy, r_val[3:1]};
                        end
                        cpu_seq_pkg::OP_LD:
                        begin
                            do_wr = 1'b1;
                            wr_a  = {cpu_seq_pkg::GEN_ROW, 4'h0};
                            wr_d  = m_val;
                        end
                        cpu_seq_pkg::OP_ST:
                        begin
                            do_wr = 1'b1;
                            wr_a  = m_addr;
                            wr_d  = read_nib({cpu_seq_pkg::GEN_ROW, 4'h0},
                                             dmem[{cpu_seq_pkg::GEN_ROW, 4'h0}],
                                             st_r.sync.lvl, st_r.flags);
                        end
                        cpu_seq_pkg::OP_MOVI:
                        begin
                            do_wr = 1'b1;
                            wr_a  = m_addr;
                            wr_d  = imm;
                        end
                        cpu_seq_pkg::OP_JUMP: st_nxt.pc = tgt;
                        cpu_seq_pkg::OP_CALL:
                        begin
                            st_nxt.ret_stack = pc_inc;
                            st_nxt.pc        = tgt;
                        end
                        cpu_seq_pkg::OP_RET:  st_nxt.pc = st_r.ret_stack;
                        default:
                        begin
                            st_nxt.skip = 1'b0;
                        end
                    endcase
                end
            end
            default:
            begin
                st_nxt.fsm = cpu_seq_pkg::ST_FETCH;
            end
        endcase

        // Route a nibble write to ports, status word, zero area or memory
        if (do_wr)
        begin
            if (is_port(wr_a))
            begin
                st_nxt.port_data[{wr_a[1:0], 2'b00} +: cpu_seq_pkg::NIB_W] = wr_d;
                st_nxt.port_oe[{wr_a[1:0], 2'b00} +: cpu_seq_pkg::NIB_W]   = cpu_seq_pkg::NIB_ONES;
            end
            else if (is_zero_area(wr_a))
            begin
                dm_we = 1'b0;
            end
            else if (wr_a == cpu_seq_pkg::STATUS_LOW_ADDR)
            begin
                st_nxt.flags.bcd = wr_d[cpu_seq_pkg::BCD_BIT];
            end
            else if (wr_a == cpu_seq_pkg::STATUS_FLAG_ADDR)
            begin
                st_nxt.flags.cmp = wr_d[cpu_seq_pkg::CMP_BIT];
                st_nxt.flags.cy  = wr_d[cpu_seq_pkg::CY_BIT];
                st_nxt.flags.z   = wr_d[cpu_seq_pkg::Z_BIT];
            end
            else
            begin
                dm_we    = 1'b1;
                dm_waddr = wr_a;
                dm_wdata = wr_d;
            end
        end

        // Arithmetic flags win over a status word write in the same step
        if (fl_upd)
        begin
            st_nxt.flags.cy = res[4];
            if (res[3:0] != cpu_seq_pkg::NIB_ZERO)
            begin
                st_nxt.flags.z = 1'b0;
            end
            else if (!st_r.flags.cmp)
            begin
                st_nxt.flags.z = 1'b1;
            end
            // zero result under hold keeps flag
            else
            begin
                st_nxt.flags.z = st_r.flags.z;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            // Clear everything, then load the state code, counter and flags from their reset constants
            st_r           <= '0;
            st_r.fsm       <= cpu_seq_pkg::ST_FETCH;
            st_r.pc        <= cpu_seq_pkg::RESET_PC;
            st_r.flags     <= cpu_seq_pkg::STATUS_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Memory write ports; contents are not reset
    always_ff @(posedge clk_i)
    begin
        if (dm_we)
        begin
            dmem[dm_waddr] <= dm_wdata;
        end
        if (prog_we_i)
        begin
            rom[prog_addr_i] <= prog_wdata_i;
        end
    end

    // Outputs straight from state
    assign pin_o                = st_r.port_data;
    assign pin_oe_o             = st_r.port_oe;
    assign instr_addr_o         = st_r.pc;
    assign status_flag_nibble_o = {st_r.flags.cmp, st_r.flags.cy, st_r.flags.z, 1'b0};
    assign status_word_o        = {3'b000, st_r.flags.bcd};

endmodule : cpu_sequencer_and_status_word

//--- testbench/cpu_sequencer_and_status_word_assertions.sv
`timescale 1ns/10ps
module cpu_sequencer_and_status_word_assertions (
    // Clock, reset and run control
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        hold_i,
    // Observed outputs
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe_o,
    input wire logic [8:0]  instr_addr_o,
    input wire logic [3:0]  status_flag_nibble_o,
    input wire logic [3:0]  status_word_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_reset_clear;
        $rose(arst_n_i) |-> {instr_addr_o, status_flag_nibble_o, status_word_o} == 17'h00000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
    property p_step_spacing; $changed(instr_addr_o) |=> $stable(instr_addr_o); endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("counter moved twice");
    property p_hold_counter; hold_i [*4] |-> $stable(instr_addr_o); endproperty
    a_hold_counter: assert property (p_hold_counter) else $error("counter moved in hold");
    property p_hold_flags; hold_i [*4] |-> $stable({status_flag_nibble_o, status_word_o}); endproperty
    a_hold_flags: assert property (p_hold_flags) else $error("flags moved in hold");
    property p_flag_spacing; $changed(status_flag_nibble_o) |=> $stable(status_flag_nibble_o); endproperty
    a_flag_spacing: assert property (p_flag_spacing) else $error("flags moved twice");
    property p_zero_bits; status_flag_nibble_o[0] == 1'b0 && status_word_o[3:1] == 3'h0; endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed zero bit set");
    property p_oe_sticky; ($past(pin_oe_o) & ~pin_oe_o) == 12'h000; endproperty
    a_oe_sticky: assert property (p_oe_sticky) else $error("output enable dropped");
    property p_drive_only_oe; (pin_o & ~pin_oe_o) == 12'h000; endproperty
    a_drive_only_oe: assert property (p_drive_only_oe) else $error("undriven data");
endmodule : cpu_sequencer_and_status_word_assertions

//--- testbench/test_cpu_sequencer_and_status_word.sv
`timescale 1ns/10ps
module test_cpu_sequencer_and_status_word;
    typedef struct packed {
        logic [8:0]  pc;
        logic [3:0]  fl;
        logic [3:0]  wd;
        logic [11:0] oe;
        logic [11:0] po;
    } note_s;
    logic        clk_i        = 1'b0;
    logic        arst_n_i     = 1'b0;
    logic        prog_we_i    = 1'b0;
    logic [8:0]  prog_addr_i  = 9'h000;
    logic [15:0] prog_wdata_i = 16'h0000;
    logic        hold_i       = 1'b1;
    logic [11:0] ext_pins     = 12'h000;
    logic [11:0] pin_i;
    logic [11:0] pin_o;
    logic [11:0] pin_oe_o;
    logic [8:0]  instr_addr_o;
    logic [3:0]  status_flag_nibble_o;
    logic [3:0]  status_word_o;
    logic [3:0]  a, b, r, c, d, p, q;
    logic [8:0]  at;
    note_s       notes[$];
    note_s       got;
    int          num_errors   = 0;
    int          compares     = 0;

    // Clock and pin wire level: driven bits show the port data
    always #5 clk_i = ~clk_i;
    assign pin_i = (pin_o & pin_oe_o) | (ext_pins & ~pin_oe_o);

    cpu_sequencer_and_status_word uut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i),
        .prog_wdata_i(prog_wdata_i), .hold_i(hold_i), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .instr_addr_o(instr_addr_o),
        .status_flag_nibble_o(status_flag_nibble_o), .status_word_o(status_word_o)
    );

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One program word per edge
    task automatic put(input logic [4:0] op, input logic [6:0] m, input logic [3:0] n);
        @(posedge clk_i);
        #1;
        prog_we_i    = 1'b1;
        prog_addr_i  = at;
        prog_wdata_i = {op, m, n};
        at           = at + 9'h001;
    endtask : put

    task automatic tally_and_finish;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Compare the oldest note when the counter reaches its address
    always @(negedge clk_i)
    begin
        if (notes.size() > 0 && instr_addr_o === notes[0].pc)
        begin
            got = notes.pop_front();
            check({8'h00, status_flag_nibble_o}, {8'h00, got.fl}, "flags");
            check({8'h00, status_word_o}, {8'h00, got.wd}, "word");
            check(pin_oe_o, got.oe, "enable");
            check(pin_o, got.po, "port");
        end
    end

    initial
    begin
        void'($urandom(93));
        a = {1'b0, 3'($urandom)};
        b = {1'b0, 3'($urandom)};
        c = 4'($urandom_range(9, 1));
        d = 4'($urandom);
        p = 4'($urandom);
        ext_pins = 12'($urandom);
        q = ext_pins[7:4];
        r = a + b;
        repeat (12) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        at = 9'h000;
        put(5'h17, 7'h10, a); put(5'h01, 7'h10, b); put(5'h17, 7'h7f, 4'h8);
        put(5'h05, 7'h10, r); put(5'h17, 7'h7f, 4'ha); put(5'h05, 7'h10, r);
        put(5'h05, 7'h10, r + 4'h1); put(5'h0e, 7'h10, 4'h0); put(5'h17, 7'h7f, 4'h0);
        put(5'h10, 7'h10, r); put(5'h17, 7'h7f, 4'h0); put(5'h17, 7'h7e, 4'hf);
        put(5'h17, 7'h11, 4'h9); put(5'h01, 7'h11, c); put(5'h10, 7'h11, c - 4'h1);
        put(5'h17, 7'h7f, 4'h0); put(5'h17, 7'h7f, 4'h4); put(5'h17, 7'h01, d);
        put(5'h14, 7'h00, 4'h1); put(5'h10, 7'h01, {1'b1, d[3:1]}); put(5'h17, 7'h7f, 4'hf);
        put(5'h17, 7'h75, 4'hf); put(5'h10, 7'h75, 4'h0); put(5'h17, 7'h7f, 4'hf);
        put(5'h17, 7'h70, p); put(5'h19, 7'h03, 4'h0); put(5'h15, 7'h71, 4'h0);
        put(5'h10, 7'h00, q); put(5'h17, 7'h7f, 4'hf); put(5'h17, 7'h7e, 4'h0);
        put(5'h17, 7'h7f, 4'h4); put(5'h07, 7'h10, 4'h0); put(5'h0c, 7'h10, 4'h0);
        put(5'h11, 7'h00, q ^ (r - 4'h1)); put(5'h17, 7'h7f, 4'h8); put(5'h12, 7'h00, 4'h0);
        put(5'h17, 7'h7f, 4'hf); put(5'h16, 7'h72, 4'h0); put(5'h18, 7'h02, 4'h6);
        at = 9'h030;
        put(5'h1a, 7'h00, 4'h0);
        @(posedge clk_i);
        #1;
        prog_we_i = 1'b0;
        // Expected status at chosen counter values
        notes.push_back('{9'h002, {2'b00, r == 4'h0, 1'b0}, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h004, 4'h8, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h006, 4'ha, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h007, 4'hc, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h009, 4'h4, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h00b, 4'h4, 4'h0, 12'h000, 12'h000});
        notes.push_back('{9'h010, {2'b01, c == 4'h1, 1'b0}, 4'h1, 12'h000, 12'h000});
        notes.push_back('{9'h015, {1'b0, d[0], 2'b00}, 4'h1, 12'h000, 12'h000});
        notes.push_back('{9'h01d, {1'b0, d[0], 2'b00}, 4'h1, 12'h00f, {8'h00, p}});
        notes.push_back('{9'h020, {1'b0, r == 4'h0, r == 4'h1, 1'b0}, 4'h0, 12'h00f, {8'h00, p}});
        notes.push_back('{9'h026, 4'h8, 4'h0, 12'hf0f, {q ^ (r - 4'h1), 4'h0, p}});
        hold_i = 1'b0;
        for (int i = 0; i < 400 && notes.size() > 0; i++)
            @(posedge clk_i);
        // all reached, ending on the jump to itself
        #1;
        check(12'(notes.size()), 12'h000, "pending");
        check({3'h0, instr_addr_o}, 12'h026, "counter");
        hold_i = 1'b1;
        repeat (6) @(posedge clk_i);
        tally_and_finish();
    end
endmodule : test_cpu_sequencer_and_status_word

bind cpu_sequencer_and_status_word cpu_sequencer_and_status_word_assertions u_chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hold_i(hold_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .instr_addr_o(instr_addr_o), .status_flag_nibble_o(status_flag_nibble_o),
    .status_word_o(status_word_o)
);
